/* File: logic/adcspi_command_decoder.sv */
// Module: serial command decoder with readout sequencing
`timescale 1ns/1ps
module adcspi_command_decoder
    import adcspi_pkg::*;
#(
    parameter int FIFO_DEPTH = 8,
    parameter int NREGS = 32
)(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic csN,
    input wire logic sclk,
    input wire logic din,
    output logic dout,
    output logic doutOeN,
    input wire logic frameValid,
    output logic frameReady,
    input wire logic [FRAME_BITS-1:0] frameData,
    output logic dataReadyN,
    output logic convRun,
    output logic standby,
    output logic contMode,
    output logic filterRestart,
    output logic busy
);
    localparam int CW = 5;
    localparam int FCW = $clog2(FRAME_BITS + 1);

    typedef struct packed {
        adcspi_pins_t s1;
        adcspi_pins_t s2;
        logic sclkD;
        logic [2:0] bitCnt;
        logic [7:0] shIn;
        logic [FRAME_BITS-1:0] shOut;
        logic [FCW-1:0] outLeft;
        logic dout;
        logic doutOeN;
        adcspi_phase_t phase;
        logic isWrite;
        logic [ADDR_BITS-1:0] addr;
        logic [ADDR_BITS-1:0] left;
        logic [FRAME_BITS-1:0] latest;
        logic haveLatest;
        logic stopPend;
        logic [CW-1:0] busyCnt;
        logic dataReadyN;
        logic convRun;
        logic standby;
        logic contMode;
        logic filterRestart;
        logic rdPend;
        logic busy;
    } adcspi_st_t;

    adcspi_st_t st;
    adcspi_st_t next_st;
    logic [REG_BITS-1:0] regs [NREGS];
    adcspi_regreq_t regReq;
    logic fifoValid;
    logic fifoPop;
    logic [FRAME_BITS-1:0] fifoData;
    logic sclkRise;
    logic sclkFall;
    logic csActive;
    logic [7:0] byteNow;

    // Frame buffer between conversion path and output register
    adcspi_fifo #(.WIDTH(FRAME_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
        .mclk(mclk),
        .arst_n(arst_n),
        .inValid(frameValid),
        .inReady(frameReady),
        .inData(frameData),
        .outValid(fifoValid),
        .outReady(fifoPop),
        .outData(fifoData)
    );

    assign csActive = !st.s2.csN;
    assign sclkRise = st.s2.sclk && !st.sclkD;
    assign sclkFall = !st.s2.sclk && st.sclkD;
    assign byteNow = {st.shIn[6:0], st.s2.din};
    // Frames wait while a frame or a byte is on the wire, so a load never meets a shift
    assign fifoPop = fifoValid && st.convRun && st.outLeft == '0 && st.bitCnt == '0 && !sclkRise;

    always_comb
    begin
        next_st = st;
        regReq = '0;
        next_st.s1 = '{csN: csN, sclk: sclk, din: din};
        next_st.s2 = st.s1;
        next_st.sclkD = st.s2.sclk;
        next_st.filterRestart = 1'b0;
        if (st.busyCnt != '0)
        begin
            next_st.busyCnt = st.busyCnt - 1'b1;
        end
        // New conversion result: data-ready low, load output in continuous mode
        if (fifoPop)
        begin
            next_st.latest = fifoData;
            next_st.haveLatest = 1'b1;
            next_st.dataReadyN = 1'b0;
            if (st.contMode)
            begin
                next_st.shOut = fifoData;
                next_st.outLeft = FCW'(FRAME_BITS);
            end
            if (st.stopPend)
            begin
                next_st.convRun = 1'b0;
                next_st.stopPend = 1'b0;
            end
        end
        if (!csActive)
        begin
            next_st.bitCnt = '0;
            next_st.phase = ADCSPI_CMD;
            next_st.doutOeN = 1'b1;
            next_st.rdPend = 1'b0;
        end
        else
        begin
            next_st.doutOeN = 1'b0;
            if (sclkRise)
            begin
                next_st.dout = st.shOut[FRAME_BITS-1];
                next_st.shOut = {st.shOut[FRAME_BITS-2:0], 1'b0};
                next_st.dataReadyN = 1'b1;
                if (st.outLeft != '0)
                begin
                    next_st.outLeft = st.outLeft - 1'b1;
                end
            end
            if (sclkFall)
            begin
                next_st.shIn = byteNow;
                next_st.bitCnt = st.bitCnt + 1'b1;
                if (st.phase == ADCSPI_CMD && st.bitCnt == BIT_SEVENTH)
                begin
                    // Seventh edge: bit 0 not yet in, so compare the first seven bits
                    if (!st.standby || byteNow[6:0] == OP_WAKE[7:1])
                    begin
                        case ({byteNow[6:0], 1'b0})
                            OP_WAKE:
                            begin
                                next_st.standby = 1'b0;
                                next_st.busyCnt = CW'(DECODE_CLKS);
                            end
                            OP_STANDBY:
                            begin
                                next_st.standby = 1'b1;
                                next_st.convRun = 1'b0;
                            end
                            OP_RESET:
                            begin
                                next_st.filterRestart = 1'b1;
                                next_st.busyCnt = CW'(RESET_CLKS);
                                next_st.convRun = 1'b0;
                                next_st.stopPend = 1'b0;
                                next_st.contMode = 1'b1;
                            end
                            OP_START:
                            begin
                                if (!st.convRun)
                                begin
                                    next_st.convRun = 1'b1;
                                    next_st.filterRestart = 1'b1;
                                end
                                next_st.stopPend = 1'b0;
                            end
                            OP_STOP:
                            begin
                                next_st.stopPend = st.convRun;
                            end
                            OP_RDATA:
                            begin
                                // Load waits for the eighth edge so the last command bit does not shift it
                                next_st.rdPend = !st.contMode && st.haveLatest;
                            end
                            default:
                            begin
                                next_st.rdPend = 1'b0;
                            end
                        endcase
                    end
                end
                if (st.bitCnt == BIT_EIGHTH)
                begin
                    case (st.phase)
                        ADCSPI_CMD:
                        begin
                            // Eighth edge: register opcodes
                            if (!st.standby && byteNow[7:5] == OP_REGISTER_READ_CMD && !st.contMode)
                            begin
                                next_st.phase = ADCSPI_COUNT;
                                next_st.isWrite = 1'b0;
                                next_st.addr = byteNow[ADDR_BITS-1:0];
                            end
                            else if (!st.standby && byteNow[7:5] == OP_REGISTER_WRITE_CMD)
                            begin
                                next_st.phase = ADCSPI_COUNT;
                                next_st.isWrite = 1'b1;
                                next_st.addr = byteNow[ADDR_BITS-1:0];
                            end
                            else if (!st.standby && byteNow[7:1] == OP_RDC[7:1])
                            begin
                                // Continuous on or off needs bit 0, so it waits for the eighth edge
                                next_st.contMode = !byteNow[0];
                            end
                            if (st.rdPend)
                            begin
                                next_st.shOut = st.latest;
                                next_st.outLeft = FCW'(FRAME_BITS);
                                next_st.rdPend = 1'b0;
                            end
                            // A running reset countdown is longer and must not be cut short
                            if (st.busyCnt < CW'(DECODE_CLKS))
                            begin
                                next_st.busyCnt = CW'(DECODE_CLKS);
                            end
                        end
                        ADCSPI_COUNT:
                        begin
                            next_st.left = byteNow[ADDR_BITS-1:0];
                            next_st.phase = st.isWrite ? ADCSPI_WDATA : ADCSPI_RDATA;
                            if (!st.isWrite)
                            begin
                                next_st.shOut = {regs[st.addr], (FRAME_BITS-REG_BITS)'(0)};
                            end
                        end
                        default:
                        begin
                            if (st.phase == ADCSPI_WDATA)
                            begin
                                regReq = '{wrStb: 1'b1, addr: st.addr, data: byteNow};
                            end
                            next_st.addr = st.addr + 1'b1;
                            next_st.left = st.left - 1'b1;
                            if (st.phase == ADCSPI_RDATA)
                            begin
                                next_st.shOut = {regs[st.addr + 1'b1], (FRAME_BITS-REG_BITS)'(0)};
                            end
                            if (st.left == '0)
                            begin
                                next_st.phase = ADCSPI_CMD;
                            end
                        end
                    endcase
                end
            end
        end
        next_st.busy = next_st.busyCnt != '0;
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st <= '0;
            st.s1 <= '{csN: 1'b1, sclk: 1'b0, din: 1'b0};
            st.s2 <= '{csN: 1'b1, sclk: 1'b0, din: 1'b0};
            st.doutOeN <= 1'b1;
            st.dataReadyN <= 1'b1;
            st.contMode <= 1'b1;
            st.phase <= ADCSPI_CMD;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Register store; reset command restores defaults when no busy countdown is running
    always_ff @(posedge mclk)
    begin
        for (int i = 0; i < NREGS; i++)
        begin
            if (next_st.filterRestart && st.busyCnt == '0 && next_st.busyCnt == CW'(RESET_CLKS))
            begin
                regs[i] <= RESET_REG_VAL;
            end
            else if (regReq.wrStb && regReq.addr == ADDR_BITS'(i))
            begin
                regs[i] <= regReq.data;
            end
        end
    end

    assign dout = st.dout;
    assign doutOeN = st.doutOeN;
    assign dataReadyN = st.dataReadyN;
    assign convRun = st.convRun;
    assign standby = st.standby;
    assign contMode = st.contMode;
    assign filterRestart = st.filterRestart;
    assign busy = st.busy;

    sequence s_deselected;
        st.s2.csN;
    endsequence

    a_dout_off_idle: assert property (@(posedge mclk) disable iff (!arst_n)
        s_deselected |=> doutOeN)
        else $error("output driven while deselected");
    a_reset_busy_len: assert property (@(posedge mclk) disable iff (!arst_n)
        $rose(filterRestart) && st.busyCnt == CW'(RESET_CLKS) |-> busy [*8])
        else $error("reset busy too short");
    a_standby_stops: assert property (@(posedge mclk) disable iff (!arst_n)
        $rose(standby) |-> !convRun)
        else $error("conversions run in standby");
    a_no_register_read_cmd_cont: assert property (@(posedge mclk) disable iff (!arst_n)
        st.contMode && st.phase == ADCSPI_CMD |=> st.phase == ADCSPI_CMD || st.isWrite)
        else $error("register read taken in continuous mode");
    a_stop_waits: assert property (@(posedge mclk) disable iff (!arst_n)
        st.stopPend && !fifoPop && csActive && !sclkFall |=> convRun)
        else $error("stop halted before conversion end");
    a_cont_load: assert property (@(posedge mclk) disable iff (!arst_n)
        fifoPop && st.contMode |=> st.outLeft == FCW'(FRAME_BITS))
        else $error("frame not loaded in continuous mode");
    a_data_ready_n_low: assert property (@(posedge mclk) disable iff (!arst_n)
        fifoPop |=> !dataReadyN)
        else $error("data ready not asserted");
    a_decode_gap: assert property (@(posedge mclk) disable iff (!arst_n)
        sclkFall && st.bitCnt == BIT_EIGHTH && st.phase == ADCSPI_CMD && csActive |=> busy [*3])
        else $error("decode window not held");
endmodule // adcspi_command_decoder

/* File: logic/adcspi_fifo.sv */
// Module: small valid/ready FIFO for conversion frames
`timescale 1ns/1ps
module adcspi_fifo
    import adcspi_pkg::*;
#(
    parameter int WIDTH = 216,
    parameter int DEPTH = 8
)(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic notFull;
    } adcspi_fifo_st_t;
    adcspi_fifo_st_t st;
    adcspi_fifo_st_t next_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    assign inReady = st.notFull;
    assign outValid = st.cnt != '0;
    assign outData = mem[st.rp];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    always_comb
    begin
        next_st = st;
        if (push)
        begin
            next_st.wp = (st.wp == AW'(DEPTH-1)) ? '0 : st.wp + 1'b1;
        end
        if (pop)
        begin
            next_st.rp = (st.rp == AW'(DEPTH-1)) ? '0 : st.rp + 1'b1;
        end
        next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
        next_st.notFull = next_st.cnt != (AW+1)'(DEPTH);
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st <= '{wp: '0, rp: '0, cnt: '0, notFull: 1'b1};
        end
        else
        begin
            st <= next_st;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (push)
        begin
            mem[st.wp] <= inData;
        end
    end

    a_fifo_no_overflow: assert property (@(posedge mclk) disable iff (!arst_n)
        st.cnt <= (AW+1)'(DEPTH))
        else $error("fifo count above depth");
endmodule // adcspi_fifo

/* File: logic/adcspi_pkg.sv */
// Package: constants and types of the serial command decoder
package adcspi_pkg;
    localparam logic [7:0] OP_WAKE = 8'h02;
    localparam logic [7:0] OP_STANDBY = 8'h04;
    localparam logic [7:0] OP_RESET = 8'h06;
    localparam logic [7:0] OP_START = 8'h08;
    localparam logic [7:0] OP_STOP = 8'h0A;
    localparam logic [7:0] OP_RDC = 8'h10;
    localparam logic [7:0] OP_SDC = 8'h11;
    localparam logic [7:0] OP_RDATA = 8'h12;
    localparam logic [2:0] OP_REGISTER_READ_CMD = 3'h1;
    localparam logic [2:0] OP_REGISTER_WRITE_CMD = 3'h2;
    localparam int FRAME_BITS = 216;
    localparam int REG_BITS = 8;
    localparam int ADDR_BITS = 5;
    localparam int RESET_CLKS = 18;
    localparam int DECODE_CLKS = 4;
    localparam logic [2:0] BIT_SEVENTH = 3'h6;
    localparam logic [2:0] BIT_EIGHTH = 3'h7;
    localparam logic [7:0] RESET_REG_VAL = 8'h00;

    typedef enum {ADCSPI_CMD, ADCSPI_COUNT, ADCSPI_RDATA, ADCSPI_WDATA} adcspi_phase_t;

    // Register-file write request from the command port
    typedef struct packed {
        logic wrStb;
        logic [ADDR_BITS-1:0] addr;
        logic [REG_BITS-1:0] data;
    } adcspi_regreq_t;

    // Serial pin bundle seen by the device
    typedef struct packed {
        logic csN;
        logic sclk;
        logic din;
    } adcspi_pins_t;
endpackage

/* File: test/adcspi_host_model.sv */
// Host model: serial master driving the decoder pins
`timescale 1ns/1ps
module adcspi_host_model
    import adcspi_pkg::*;
(
    input wire logic mclk,
    input wire logic dout,
    input wire logic doutOeN,
    output adcspi_pins_t pins
);
    localparam int HALF = 4;
    localparam int GAP = 2 * DECODE_CLKS;

    initial pins = '{csN: 1'b1, sclk: 1'b0, din: 1'b0};

    task automatic waitM(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic sel(input logic on);
        waitM(HALF);
        pins.csN <= ~on;
        waitM(HALF);
    endtask

    // Shift n bits MSB first; pins change at mclk rise
    task automatic xfer(input int n, input logic [FRAME_BITS-1:0] tx, output logic [FRAME_BITS-1:0] rx);
        rx = '0;
        for (int i = n - 1; i >= 0; i--)
        begin
            pins.sclk <= 1'b1;
            pins.din <= tx[i];
            waitM(HALF);
            pins.sclk <= 1'b0;
            waitM(HALF);
            rx[i] = doutOeN ? ~dout : dout;
        end
        // Released data line shows the inverse
        pins.din <= ~tx[0];
        waitM(GAP);
    endtask
endmodule // adcspi_host_model

/* File: test/testbench.sv */
// Testbench: command decoder with host model and frame source
`timescale 1ns/1ps
module testbench;
    import adcspi_pkg::*;
    localparam int DEPTH = 8;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic frameValid = 1'b0;
    logic [FRAME_BITS-1:0] frameData = '0;
    logic dout, doutOeN, frameReady, dataReadyN, convRun, standby, contMode, filterRestart, busy, ok;
    logic [FRAME_BITS-1:0] rx, f;
    logic [FRAME_BITS-1:0] q[$];
    logic [31:0] seed = 32'h5494;
    logic [4:0] a;
    logic [15:0] d;
    adcspi_pins_t pins;
    int err_total = 0;
    int checks = 0;
    int frCnt = 0;
    int busyRun = 0;
    int lastRun = 0;

    always #50 mclk = ~mclk;

    always @(posedge mclk)
    begin
        if (filterRestart === 1'b1)
            frCnt++;
        if (busy !== 1'b1 && busyRun != 0)
            lastRun <= busyRun;
        busyRun <= (busy === 1'b1) ? busyRun + 1 : 0;
    end

    adcspi_command_decoder #(.FIFO_DEPTH(DEPTH), .NREGS(32)) DUT (.mclk(mclk), .arst_n(arst_n),
        .csN(pins.csN), .sclk(pins.sclk), .din(pins.din), .dout(dout), .doutOeN(doutOeN),
        .frameValid(frameValid), .frameReady(frameReady), .frameData(frameData),
        .dataReadyN(dataReadyN), .convRun(convRun), .standby(standby), .contMode(contMode),
        .filterRestart(filterRestart), .busy(busy));

    adcspi_host_model host (.mclk(mclk), .dout(dout), .doutOeN(doutOeN), .pins(pins));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [FRAME_BITS-1:0] mkFrame();
        logic [FRAME_BITS-1:0] r;
        r = '0;
        repeat (7) r = (r << 32) | FRAME_BITS'(rnd());
        return r;
    endfunction

    task automatic end_sim();
        $display("Counts: %0d compares, %0d mismatches", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input logic [FRAME_BITS-1:0] seen, input logic [FRAME_BITS-1:0] exp, input string what);
        checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask

    task automatic push(input logic [FRAME_BITS-1:0] v, output logic taken);
        @(posedge mclk);
        frameValid <= 1'b1;
        frameData <= v;
        taken = 1'b0;
        for (int i = 0; i < 20 && taken !== 1'b1; i++)
        begin
            @(posedge mclk);
            taken = frameReady;
        end
        frameValid <= 1'b0;
    endtask

    task automatic waitDrdy();
        for (int n = 0; dataReadyN !== 1'b0; n++)
        begin
            @(posedge mclk);
            if (n > 4000)
            begin
                check(1'b1, 1'b0, "data-ready timeout");
                end_sim();
            end
        end
    endtask

    task automatic cmd(input logic [7:0] b);
        host.xfer(8, FRAME_BITS'(b), rx);
    endtask

    task automatic readFrame(input logic [FRAME_BITS-1:0] exp);
        waitDrdy();
        host.xfer(FRAME_BITS, '0, rx);
        check(rx, exp, "frame");
    endtask

    initial
    begin
        #5000000;
        check(1'b1, 1'b0, "global timeout");
        end_sim();
    end

    initial
    begin
        repeat (20) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        check(doutOeN, 1'b1, "oe while deselected");
        check(contMode, 1'b1, "continuous at power-up");
        check({convRun, standby, dataReadyN}, 3'b001, "modes at reset");
        $display("Test reset done");
        for (int i = 0; i <= DEPTH; i++)
        begin
            f = mkFrame();
            push(f, ok);
            if (ok === 1'b1)
                q.push_back(f);
        end
        check(FRAME_BITS'(q.size()), FRAME_BITS'(DEPTH), "fifo fill");
        $display("Test fifo fill done");
        host.sel(1'b1);
        check(doutOeN, 1'b0, "oe while selected");
        host.xfer(7, FRAME_BITS'(OP_START >> 1), rx);
        check(convRun, 1'b1, "start at seventh fall");
        check(FRAME_BITS'(frCnt), FRAME_BITS'(1), "filter restart");
        host.xfer(1, FRAME_BITS'(OP_START), rx);
        foreach (q[i])
            readFrame(q[i]);
        $display("Test start and drain done");
        cmd(OP_START);
        check(FRAME_BITS'(frCnt), FRAME_BITS'(1), "start while running");
        cmd(OP_STOP);
        check(FRAME_BITS'(lastRun), FRAME_BITS'(DECODE_CLKS), "decode time");
        check(convRun, 1'b1, "conversion completes");
        f = mkFrame();
        push(f, ok);
        readFrame(f);
        check(convRun, 1'b0, "stopped after frame");
        cmd(OP_STOP);
        check(FRAME_BITS'({convRun, 8'(frCnt)}), FRAME_BITS'({1'b0, 8'h01}), "stop when stopped");
        $display("Test start stop done");
        cmd(OP_SDC);
        check(contMode, 1'b0, "continuous off");
        cmd(OP_START);
        f = mkFrame();
        push(f, ok);
        waitDrdy();
        cmd(OP_RDATA);
        host.xfer(FRAME_BITS, '0, rx);
        check(rx, f, "on-demand read");
        $display("Test on-demand read done");
        a = 5'(rnd()) & 5'h1E;
        d = 16'(rnd());
        cmd({OP_REGISTER_WRITE_CMD, a});
        cmd(8'h01);
        cmd(d[15:8]);
        cmd(d[7:0]);
        cmd({OP_REGISTER_READ_CMD, a});
        cmd(8'h01);
        host.xfer(16, '0, rx);
        check(rx[15:0], d, "register read back");
        $display("Test registers done");
        cmd(OP_STANDBY);
        check(standby, 1'b1, "standby on");
        cmd(OP_RDC);
        check(contMode, 1'b0, "ignored in standby");
        cmd(OP_WAKE);
        check(standby, 1'b0, "standby off");
        cmd(OP_RDC);
        check(contMode, 1'b1, "continuous on");
        cmd(OP_SDC);
        $display("Test standby done");
        cmd(OP_RESET);
        repeat (RESET_CLKS + 2) @(posedge mclk);
        check(FRAME_BITS'(lastRun), FRAME_BITS'(RESET_CLKS), "reset time");
        check(FRAME_BITS'(frCnt), FRAME_BITS'(3), "reset restarts filter");
        cmd({OP_REGISTER_READ_CMD, a});
        cmd(OP_SDC);
        check(contMode, 1'b0, "read refused in continuous mode");
        cmd({OP_REGISTER_READ_CMD, a});
        cmd(8'h00);
        host.xfer(8, '0, rx);
        check(rx[7:0], RESET_REG_VAL, "register default");
        host.sel(1'b0);
        check(doutOeN, 1'b1, "oe off after deselect");
        $display("Test reset command done");
        end_sim();
    end
endmodule // testbench
